// *** hw/dpda_pkg.sv ***
// dpda_pkg: constants shared by the dual port dram arbiter design
// assumes a single 100 MHz clock; strobe timing counted in whole-clock phases, refresh divide in refresh clocks
package dpda_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned PHASE_W       = 4;

  // ---------------------------------------------------------------
  // timing, in whole-clock phases of the master clock; REF_DIVIDE in refresh clocks
  // ---------------------------------------------------------------
  localparam logic [5:0]  REF_DIVIDE    = 6'h3f;  // 64 refresh clocks, counted 63 down to 0
  localparam logic [PHASE_W-1:0] ACC_ROW_PH    = 4'h1;  // row strobe after grant
  localparam logic [PHASE_W-1:0] ACC_COL_PH    = 4'h3;  // column address, write window
  localparam logic [PHASE_W-1:0] ACC_COL_STROBE_ENABLE_N_PH  = 4'h4;  // column strobe enable
  localparam logic [PHASE_W-1:0] ACC_DONE_PH   = 4'h9;  // row strobe off, acknowledge
  localparam logic [PHASE_W-1:0] REF_ROW_PH    = 4'h1;  // row strobe after refresh address
  localparam logic [PHASE_W-1:0] REF_HIGH_PH   = 4'h9;  // 8 clocks low
  localparam logic [PHASE_W-1:0] REF_DONE_PH   = 4'hf;  // 8 clocks high

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REF_ROW_RST = 10'h000;

  typedef enum logic [2:0] {DPDA_IDLE, DPDA_ACCESS, DPDA_HOLD, DPDA_REFRESH} dpda_state_t;

endpackage

// *** hw/dpda_sync3.sv ***
// dpda_sync3: three-flop input synchroniser with agreement filter
// assumes d comes from outside the clk domain
`timescale 1ns/10ps
module dpda_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // data
  input  wire logic d,
  output logic      q
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // first stage feeds only the second; q changes once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      q     <= 1'b1;
    end else if (clk_en) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q <= s3_ff;
      end
    end
  end
endmodule

// *** hw/dpda_top.sv ***
// dpda_top: two-port dram arbiter, strobe timer, address mux and refresh
// assumes requests, addresses and refresh clock arrive asynchronously
//---------------------------------------------------------------------
//---------------------------------------------------------------------
`timescale 1ns/10ps
module dpda_top
  import dpda_pkg::*;
#(
  parameter bit ADDR_LATCHED = 1'b1
) (
  // clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  // requesters
  input  wire logic                       port1_request_n,
  input  wire logic                       port2_request_n,
  input  wire logic [dpda_pkg::ADDR_W-1:0] row_addr_in,
  input  wire logic [dpda_pkg::ADDR_W-1:0] col_addr_in,
  // refresh pacing
  input  wire logic                       refresh_clock,
  // arbitration outputs
  output logic                            port1_select_n,
  output logic                            port2_select_n,
  output logic                            grant,
  // dram timing outputs
  output logic [dpda_pkg::ADDR_W-1:0]      dram_addr_out,
  output logic                            row_strobe_n,
  output logic                            col_strobe_enable_n,
  output logic                            write_window,
  output logic                            transfer_ack_n
);
  import dpda_pkg::*;

  //---------------------------------------------------------------
  // input synchronisers
  //---------------------------------------------------------------
  logic port1_request_n_n_s;
  logic port2_request_n_n_s;
  logic rclk_s;
  logic rclk_d_ff;
  logic port2_request_n_fall_ff;
  logic [ADDR_W-1:0] row_s1_ff;
  logic [ADDR_W-1:0] row_s2_ff;
  logic [ADDR_W-1:0] col_s1_ff;
  logic [ADDR_W-1:0] col_s2_ff;

  dpda_sync3 u_sync_port1_request_n (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d       (port1_request_n),
    .q       (port1_request_n_n_s)
  );

  dpda_sync3 u_sync_port2_request_n (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d       (port2_request_n),
    .q       (port2_request_n_n_s)
  );

  dpda_sync3 u_sync_rclk (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d       (refresh_clock),
    .q       (rclk_s)
  );

  // port2 retimed on the falling edge so a tie resolves to port1
  always_ff @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port2_request_n_fall_ff <= 1'b1;
    end else if (clk_en) begin
      port2_request_n_fall_ff <= port2_request_n_n_s;
    end
  end

  // addresses are a bus held stable by the requester, two flops suffice
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_s1_ff <= '0;
      row_s2_ff <= '0;
      col_s1_ff <= '0;
      col_s2_ff <= '0;
    end else if (clk_en) begin
      row_s1_ff <= row_addr_in;
      row_s2_ff <= row_s1_ff;
      col_s1_ff <= col_addr_in;
      col_s2_ff <= col_s1_ff;
    end
  end

  //---------------------------------------------------------------
  // refresh request generation
  //---------------------------------------------------------------
  logic [5:0]        ref_div_ff;
  logic              ref_pend_ff;
  logic [ADDR_W-1:0] ref_row_ff;
  logic              ref_tick;
  logic              ref_done;

  assign ref_tick = rclk_s & ~rclk_d_ff & (ref_div_ff == 6'h00);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rclk_d_ff  <= 1'b1;
      ref_div_ff <= REF_DIVIDE;
    end else if (clk_en) begin
      rclk_d_ff <= rclk_s;
      if (rclk_s && !rclk_d_ff) begin
        ref_div_ff <= (ref_div_ff == 6'h00) ? REF_DIVIDE : ref_div_ff - 6'h01;
      end
    end
  end

  // new tick wins over the clear of a serviced request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (ref_tick) begin
        ref_pend_ff <= 1'b1;
      end else if (ref_done) begin
        ref_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_row_ff <= REF_ROW_RST;
    end else if (clk_en && ref_done) begin
      ref_row_ff <= ref_row_ff + 10'h001;
    end
  end

  //---------------------------------------------------------------
  // first stage arbitration: select
  //---------------------------------------------------------------
  logic        port1_select_n_ff;
  logic        port2_select_n_ff;
  logic        release_req;
  dpda_state_t state_ff;

  // the selected requester's release ends its cycle
  assign release_req = (port1_select_n_ff & port1_request_n_n_s) | (port2_select_n_ff & port2_request_n_fall_ff);

  // only one select at a time keeps the two address buses apart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port1_select_n_ff <= 1'b0;
      port2_select_n_ff <= 1'b0;
    end else if (clk_en) begin
      if (!port1_select_n_ff && !port2_select_n_ff) begin
        if (!port1_request_n_n_s) begin
          port1_select_n_ff <= 1'b1;
        end else if (!port2_request_n_fall_ff) begin
          port2_select_n_ff <= 1'b1;
        end
      end else if (state_ff == DPDA_HOLD && release_req) begin
        port1_select_n_ff <= 1'b0;
        port2_select_n_ff <= 1'b0;
      end
    end
  end

  //---------------------------------------------------------------
  // second stage: cycle sequencer in whole-clock phases
  //---------------------------------------------------------------
  logic [PHASE_W-1:0] phase_ff;
  logic               sel_any;

  assign sel_any  = port1_select_n_ff | port2_select_n_ff;
  // ends on the last precharge phase so every refresh clears pending exactly once
  assign ref_done = (state_ff == DPDA_REFRESH) && (phase_ff == REF_DONE_PH);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= DPDA_IDLE;
      phase_ff <= '0;
    end else if (clk_en) begin
      unique case (state_ff)
        DPDA_IDLE: begin
          phase_ff <= '0;
          if (ref_pend_ff) begin
            state_ff <= DPDA_REFRESH;
          end else if (sel_any && !release_req) begin
            state_ff <= DPDA_ACCESS;
          end
        end
        DPDA_ACCESS: begin
          phase_ff <= phase_ff + 4'h1;
          if (phase_ff == ACC_DONE_PH - 4'h1) begin
            state_ff <= DPDA_HOLD;
          end
        end
        DPDA_HOLD: begin
          if (release_req) begin
            state_ff <= DPDA_IDLE;
          end
        end
        DPDA_REFRESH: begin
          phase_ff <= phase_ff + 4'h1;
          if (phase_ff == REF_DONE_PH) begin
            state_ff <= DPDA_IDLE;
          end
        end
        default: begin
          state_ff <= DPDA_IDLE;
        end
      endcase
    end
  end

  //---------------------------------------------------------------
  // address latch and multiplexer
  //---------------------------------------------------------------
  logic [ADDR_W-1:0] row_lat_ff;
  logic [ADDR_W-1:0] col_lat_ff;
  logic [ADDR_W-1:0] row_src;
  logic [ADDR_W-1:0] col_src;
  logic              start_acc;

  assign start_acc = (state_ff == DPDA_IDLE) && !ref_pend_ff && sel_any && !release_req;

  // latch option captures all twenty bits as the grant rises
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_lat_ff <= '0;
      col_lat_ff <= '0;
    end else if (clk_en && start_acc) begin
      row_lat_ff <= row_s2_ff;
      col_lat_ff <= col_s2_ff;
    end
  end

  // without the latch the requester must hold its address until release
  assign row_src = ADDR_LATCHED ? row_lat_ff : row_s2_ff;
  assign col_src = ADDR_LATCHED ? col_lat_ff : col_s2_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dram_addr_out <= '0;
    end else if (clk_en) begin
      if (state_ff == DPDA_REFRESH || (state_ff == DPDA_IDLE && ref_pend_ff)) begin
        dram_addr_out <= ref_row_ff;
      end else if (state_ff == DPDA_ACCESS && phase_ff >= ACC_COL_PH - 4'h1) begin
        dram_addr_out <= col_src;
      end else if (state_ff == DPDA_HOLD) begin
        dram_addr_out <= col_src;
      end else if (start_acc) begin
        dram_addr_out <= row_s2_ff;
      end else begin
        dram_addr_out <= row_src;
      end
    end
  end

  //---------------------------------------------------------------
  // strobe and handshake outputs
  //---------------------------------------------------------------
  logic acc_on;
  logic ref_on;

  assign acc_on = (state_ff == DPDA_ACCESS);
  assign ref_on = (state_ff == DPDA_REFRESH);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port1_select_n      <= 1'b1;
      port2_select_n      <= 1'b1;
      grant               <= 1'b0;
      row_strobe_n        <= 1'b1;
      col_strobe_enable_n <= 1'b1;
      write_window        <= 1'b0;
      transfer_ack_n      <= 1'b1;
    end else if (clk_en) begin
      port1_select_n <= ~port1_select_n_ff;
      port2_select_n <= ~port2_select_n_ff;
      grant          <= start_acc | acc_on | (state_ff == DPDA_HOLD);
      // row strobe: access from ROW phase to DONE, refresh from ROW to HIGH
      row_strobe_n <= ~((acc_on && phase_ff >= ACC_ROW_PH - 4'h1
                         && phase_ff < ACC_DONE_PH - 4'h1)
                     || (ref_on && phase_ff >= REF_ROW_PH - 4'h1
                         && phase_ff < REF_HIGH_PH - 4'h1));
      col_strobe_enable_n <= ~((acc_on && phase_ff >= ACC_COL_STROBE_ENABLE_N_PH - 4'h1)
                            || state_ff == DPDA_HOLD);
      write_window   <= (acc_on && phase_ff >= ACC_COL_PH - 4'h1)
                        || state_ff == DPDA_HOLD;
      transfer_ack_n <= ~((acc_on && phase_ff == ACC_DONE_PH - 4'h1)
                       || (state_ff == DPDA_HOLD && !release_req));
    end
  end

endmodule

// *** dv/dpda_chk_sva.sv ***
// dpda_chk: port timing checks for dpda_top
// assumes clk_en held high, one clock domain
`timescale 1ns/10ps
module dpda_chk (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        port1_request_n,
  input wire logic                        port1_select_n,
  input wire logic                        port2_select_n,
  input wire logic                        grant,
  input wire logic [dpda_pkg::ADDR_W-1:0] dram_addr_out,
  input wire logic                        row_strobe_n,
  input wire logic                        col_strobe_enable_n,
  input wire logic                        write_window,
  input wire logic                        transfer_ack_n
);
  // ----------------------------------------
  // row strobe low-time counter
  // ----------------------------------------
  logic [3:0] low_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_ff <= 4'h0;
    else if (row_strobe_n) low_ff <= 4'h0;
    else if (low_ff != 4'hf) low_ff <= low_ff + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_strobe_up;
    $rose(row_strobe_n);
  endsequence
  sequence s_acc_done;
    !transfer_ack_n && row_strobe_n;
  endsequence
  chk_one_port: assert property (port1_select_n || port2_select_n)
    else $error("both selects low");
  chk_grant_sel: assert property ($rose(grant) |-> !(port1_select_n && port2_select_n))
    else $error("grant without select");
  chk_ras_follow: assert property ($rose(grant) |-> ##[1:2] !row_strobe_n)
    else $error("row strobe late");
  chk_ack_time: assert property ($rose(grant) |-> ##[8:10] s_acc_done)
    else $error("acknowledge late");
  chk_ras_width: assert property (s_strobe_up |-> low_ff == 4'h8)
    else $error("row strobe width");
  chk_col_strobe_enable_n_ww: assert property ($fell(col_strobe_enable_n) |-> write_window && grant)
    else $error("column strobe without window");
  chk_idle_quiet: assert property (!grant && !$past(grant)
    |-> col_strobe_enable_n && transfer_ack_n && !write_window)
    else $error("cycle outputs active while idle");
  chk_ack_hold: assert property (!transfer_ack_n && !port1_select_n && !port1_request_n
    |=> !transfer_ack_n)
    else $error("acknowledge dropped early");
  chk_ref_wait: assert property (!row_strobe_n && !grant |=> !grant)
    else $error("grant inside refresh");
  chk_ref_addr: assert property ($fell(row_strobe_n) && !grant |-> $stable(dram_addr_out))
    else $error("refresh address moved");
endmodule

bind dpda_top dpda_chk u_chk (.clk(clk), .sys_rst(sys_rst), .port1_request_n(port1_request_n),
  .port1_select_n(port1_select_n), .port2_select_n(port2_select_n), .grant(grant),
  .dram_addr_out(dram_addr_out), .row_strobe_n(row_strobe_n),
  .col_strobe_enable_n(col_strobe_enable_n), .write_window(write_window),
  .transfer_ack_n(transfer_ack_n));

// *** dv/dpda_cpu_pair.sv ***
// dpda_cpu_pair: two processors sharing the controller's address inputs
// assumes bench raises want bits at the falling edge
`timescale 1ns/10ps
module dpda_cpu_pair
  import dpda_pkg::*;
(
  // bench side
  input  wire logic                        clk,
  input  wire logic [1:0]                  want,
  input  wire logic [dpda_pkg::ADDR_W-1:0] r1,
  input  wire logic [dpda_pkg::ADDR_W-1:0] c1,
  input  wire logic [dpda_pkg::ADDR_W-1:0] r2,
  input  wire logic [dpda_pkg::ADDR_W-1:0] c2,
  output logic      [1:0]                  done,
  // controller side
  input  wire logic                        port1_select_n,
  input  wire logic                        port2_select_n,
  input  wire logic                        transfer_ack_n,
  output logic                             port1_request_n,
  output logic                             port2_request_n,
  output logic      [dpda_pkg::ADDR_W-1:0] row_addr_in,
  output logic      [dpda_pkg::ADDR_W-1:0] col_addr_in
);
  logic p2;
  initial begin
    done = 2'b00;
    port1_request_n = 1'b1;
    port2_request_n = 1'b1;
    row_addr_in = '0;
    col_addr_in = '0;
  end
  // address held from request until release; idle bus toggles so stale values never match
  always @(negedge clk) begin
    port1_request_n <= !(want[0] && !done[0]);
    port2_request_n <= !(want[1] && !done[1]);
    p2 = !port2_select_n || (!port2_request_n && port1_request_n);
    if (p2 || !port1_request_n) begin
      row_addr_in <= p2 ? r2 : r1;
      col_addr_in <= p2 ? c2 : c1;
    end else begin
      row_addr_in <= ~row_addr_in;
      col_addr_in <= ~col_addr_in;
    end
  end
  always @(posedge clk) begin
    if (!want[0]) done[0] <= 1'b0;
    else if (!transfer_ack_n && !port1_select_n) done[0] <= 1'b1;
    if (!want[1]) done[1] <= 1'b0;
    else if (!transfer_ack_n && !port2_select_n) done[1] <= 1'b1;
  end
endmodule

// *** dv/tb.sv ***
// tb: random two-port traffic with refresh running
// assumes dpda_cpu_pair stands in for both processors
`timescale 1ns/10ps
module tb;
  import dpda_pkg::*;
  logic clk, sys_rst, rclk, q1, q2, s1, s2, gnt, ras_n, cas_n, ww, ack_n;
  logic g_ff, ras_ff, cas_ff;
  logic [1:0] want, done;
  logic [ADDR_W-1:0] r1, c1, r2, c2, ra, ca, ma, ref_exp, er, ec;
  int error_cnt, checks, nacc, nexp, n;

  dpda_top u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .port1_request_n(q1),
    .port2_request_n(q2), .row_addr_in(ra), .col_addr_in(ca), .refresh_clock(rclk),
    .port1_select_n(s1), .port2_select_n(s2), .grant(gnt), .dram_addr_out(ma),
    .row_strobe_n(ras_n), .col_strobe_enable_n(cas_n), .write_window(ww),
    .transfer_ack_n(ack_n));
  dpda_cpu_pair u_cpu (.clk(clk), .want(want), .r1(r1), .c1(c1), .r2(r2), .c2(c2),
    .done(done), .port1_select_n(s1), .port2_select_n(s2), .transfer_ack_n(ack_n),
    .port1_request_n(q1), .port2_request_n(q2), .row_addr_in(ra), .col_addr_in(ca));

  task automatic check(string nm, logic [ADDR_W-1:0] seen, logic [ADDR_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one access per set bit of w; both bits set means a tie
  task automatic xfer(logic [1:0] w);
    r1 <= ADDR_W'($urandom);
    c1 <= ADDR_W'($urandom);
    r2 <= ADDR_W'($urandom);
    c2 <= ADDR_W'($urandom);
    want <= w;
    nexp += w[0] + w[1];
    n = 0;
    do begin @(negedge clk); n++; end while (done !== w && n < 600);
    want <= 2'b00;
    do begin @(negedge clk); n++; end while (!(s1 && s2 && !gnt) && n < 700);
    if (n >= 600) begin
      error_cnt++;
      results();
    end
  endtask

  // ----------------------------------------
  // output monitor, sampled where outputs are settled
  // ----------------------------------------
  always @(negedge clk) begin
    if (!sys_rst) begin
      if (gnt && !g_ff) begin
        nacc++;
        er = !s1 ? r1 : r2;
        ec = !s1 ? c1 : c2;
        check("port order", ADDR_W'(s1), ADDR_W'(!(want[0] && !done[0])));
      end
      if (!ras_n && ras_ff && gnt) check("row", ma, er);
      if (!ras_n && ras_ff && !gnt) begin
        check("refresh row", ma, ref_exp);
        ref_exp++;
      end
      if (!cas_n && cas_ff) check("column", ma, ec);
    end
    g_ff = gnt;
    ras_ff = ras_n;
    cas_ff = cas_n;
  end

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    rclk = 0;
    forever #50 rclk = ~rclk;
  end

  initial begin
    sys_rst = 1;
    want = 2'b00;
    {r1, c1, r2, c2} = '0;
    {error_cnt, checks, nacc, nexp} = '0;
    ref_exp = REF_ROW_RST;
    {g_ff, ras_ff, cas_ff} = 3'b011;
    void'($urandom(21262));
    repeat (5) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    xfer(2'b11);
    xfer(2'b01);
    xfer(2'b10);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (!(!ras_n && !gnt) && n < 2000) begin @(negedge clk); n++; end
      if (n >= 2000) begin
        error_cnt++;
        results();
      end
      xfer(2'($urandom_range(3, 1)));
    end
    for (int k = 0; k < 60; k++) xfer(2'($urandom_range(3, 1)));
    check("access count", ADDR_W'(nacc), ADDR_W'(nexp));
    check("refresh seen", ADDR_W'(ref_exp > REF_ROW_RST + 2), ADDR_W'(1));
    results();
  end
endmodule
